// File: shared/dma_tcm_pkg.sv
// constants, encodings and lane decode for the dma tightly coupled memory port
// assumes a 32-bit ahb-lite data bus and one instruction port plus two data banks
package dma_tcm_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MEM_AW = 22;        // word address width towards the memories
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned DATA_SEL_BIT = 23;  // bus address bit: 0 instruction, 1 data memory
  localparam int unsigned BANK_SEL_BIT = 2;   // bus address bit picking the data bank

  // ----------------------------------------------------------------
  // port numbering and bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_INSTR = 2'h0;
  localparam logic [1:0] PORT_EVEN = 2'h1;
  localparam logic [1:0] PORT_ODD = 2'h2;
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic RESP_OKAY = 1'h0;
  localparam logic RESP_ERROR = 1'h1;
  localparam logic [3:0] LANES_ALL = 4'hf;

  // data phase states of the bus slave
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_WRITE = 3'h1,
    PH_RD_ISSUE = 3'h2,
    PH_RD_MEM = 3'h3,
    PH_RD_RET = 3'h4,
    PH_RD_DONE = 3'h5,
    PH_ERR = 3'h6
  } phase_e;

  // low power sequencing states
  typedef enum logic [1:0] {
    SLP_RUN = 2'h0,
    SLP_DRAIN = 2'h1,
    SLP_SLEEP = 2'h2,
    SLP_WAKE = 2'h3
  } sleep_e;

  // byte lanes written for a given size, offset and endian select
  function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] off, input logic big);
    logic [3:0] m;
    m = LANES_ALL;
    if (size == SIZE_BYTE) begin
      m = 4'h1 << off;
    end else if (size == SIZE_HALF) begin
      m = off[1] ? 4'hc : 4'h3;
    end
    lane_mask = big ? {m[0], m[1], m[2], m[3]} : m;
  endfunction

  // which memory port a bus address reaches
  function automatic logic [1:0] target_port(input logic [31:0] addr);
    target_port = !addr[DATA_SEL_BIT] ? PORT_INSTR : (addr[BANK_SEL_BIT] ? PORT_ODD : PORT_EVEN);
  endfunction

endpackage

// File: logic/word_fifo.sv
// flip-flop fifo with valid and ready on both sides and a fill level
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [$clog2(DEPTH+1)-1:0] level_q;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  assign o_in_ready = (level_q != ($clog2(DEPTH+1))'(DEPTH));
  assign o_out_valid = (level_q != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  assign o_out_data = mem_q[rd_ptr_q];
  assign o_level = level_q;

  // storage write
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  // pointers and level
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        level_q <= level_q + 1'b1;
      end else if (pop && !push) begin
        level_q <= level_q - 1'b1;
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

// File: logic/dma_tcm_port.sv
// ahb-lite slave port letting a dma master reach the instruction and data memories,
// plus the low power standby sequencing of the core.
// assumes this is the only slave on its bus segment and inputs synchronous to i_clk_sys
//
// Summary of operation
// - only okay and error responses are ever driven
// - bus state advances only on edges with the dma clock enable high
// - little endian writes select lanes upward from offset zero
// - big endian writes select lanes downward from offset zero
// - write lanes come from size, low address bits, endian; reads return words
// - every burst type, sequential or not, is accepted
// - protection bits are ignored entirely
// - memory errors during writes are ignored; writes end okay
// - a memory error on a read gives an error response
// - error raised on next enabled cycle, as a two-cycle error response
// - ready low stretches data phase; master holds data and next address
// - address and control are registered before reaching memory
// - memory wait on a read keeps ready low until data comes
// - a bank wait during a write keeps ready low while it lasts
// - block writes alternate words between the two data banks
// - instruction memory is reached one transfer at a time, no interleave
// - a sleep request stops core clocks until irq, fiq or halt request
// - sleep entry waits until write buffers drain and memory is idle
// - the dma port keeps working while the core sleeps
// - standby flag set on sleep, cleared after wake, access one cycle later
// - error inputs are sampled only in the read data return cycle
// - write data goes out with the address and strobes
`timescale 1ns/1ns
`default_nettype none
module dma_tcm_port #(
  parameter int unsigned MEM_AW = dma_tcm_pkg::MEM_AW,
  parameter int unsigned FIFO_DEPTH = dma_tcm_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_dma_clock_enable,
  input wire logic i_big_endian_select,
  input wire logic i_dma_bus_select,
  input wire logic [31:0] i_dma_bus_address,
  input wire logic [1:0] i_dma_bus_transfer_type,
  input wire logic [2:0] i_dma_bus_size,
  input wire logic i_dma_bus_write,
  input wire logic [3:0] i_dma_bus_protection,
  input wire logic [31:0] i_dma_bus_write_data,
  input wire logic i_dma_bus_ready_in,
  output logic [31:0] o_dma_bus_read_data,
  output logic o_dma_bus_response,
  output logic o_dma_bus_ready_out,
  output logic o_instr_mem_cs,
  output logic o_instr_mem_write,
  output logic [MEM_AW-1:0] o_instr_mem_addr,
  output logic [3:0] o_instr_mem_byte_we,
  output logic [31:0] o_instr_mem_wdata,
  input wire logic [31:0] i_instr_mem_rdata,
  input wire logic i_instr_mem_wait,
  input wire logic i_instr_mem_error,
  output logic [1:0] o_data_mem_cs,
  output logic [1:0] o_data_mem_write,
  output logic [1:0][MEM_AW-1:0] o_data_mem_addr,
  output logic [1:0][3:0] o_data_mem_byte_we,
  output logic [1:0][31:0] o_data_mem_wdata,
  input wire logic [1:0][31:0] i_data_mem_rdata,
  input wire logic i_even_bank_wait,
  input wire logic i_odd_bank_wait,
  input wire logic [1:0] i_data_mem_error,
  input wire logic i_wfi_request,
  input wire logic i_irq,
  input wire logic i_fiq,
  input wire logic i_external_halt_request,
  output logic o_core_clock_run,
  output logic o_sleep_standby_flag
);
  localparam int unsigned EW = 2 + MEM_AW + 4 + 32;
  localparam int unsigned LW = $clog2(FIFO_DEPTH + 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dma_tcm_pkg::phase_e ph_q;
  dma_tcm_pkg::sleep_e slp_q;
  logic rdy_q;
  logic resp_q;
  logic [31:0] rdata_q;
  logic [1:0] tgt_q;
  logic [MEM_AW-1:0] addr_q;
  logic [3:0] lanes_q;
  logic [2:0] cs_q;
  logic [2:0] wr_q;
  logic [2:0][MEM_AW-1:0] maddr_q;
  logic [2:0][3:0] mwe_q;
  logic [2:0][31:0] mwd_q;
  logic core_run_q;
  logic standby_q;
  logic ce;
  logic accept;
  logic phase_end;
  logic push;
  logic pop;
  logic issue_rd;
  logic space_ok;
  logic any_wait;
  logic quiescent;
  logic wake;
  logic [2:0] wait_v;
  logic [2:0] free_v;
  logic [2:0][31:0] rdata_v;
  logic [2:0] err_v;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [EW-1:0] fifo_out;
  logic [LW-1:0] fifo_level;
  logic [1:0] head_tgt;

  // ----------------------------------------------------------------
  // per port views and bus qualifiers
  // ----------------------------------------------------------------
  assign ce = i_dma_clock_enable;
  assign wait_v = {i_odd_bank_wait, i_even_bank_wait, i_instr_mem_wait};
  assign rdata_v = {i_data_mem_rdata[1], i_data_mem_rdata[0], i_instr_mem_rdata};
  assign err_v = {i_data_mem_error[1], i_data_mem_error[0], i_instr_mem_error};
  assign free_v = ~cs_q | ~wait_v;
  assign any_wait = |(cs_q & wait_v);
  assign quiescent = !fifo_out_valid && (cs_q == 3'h0);
  // protection bits are left unread; seq and nonseq alike start a transfer
  assign accept = i_dma_bus_select && i_dma_bus_transfer_type[1] && i_dma_bus_ready_in;
  assign phase_end = rdy_q && (ph_q != dma_tcm_pkg::PH_IDLE);
  assign push = ce && phase_end && (ph_q == dma_tcm_pkg::PH_WRITE);
  assign space_ok = (int'(fifo_level) + int'(push)) < int'(FIFO_DEPTH);
  assign head_tgt = fifo_out[EW-1 -: 2];
  assign pop = ce && fifo_out_valid && free_v[head_tgt];
  assign issue_rd = ce && (ph_q == dma_tcm_pkg::PH_RD_ISSUE) && quiescent;

  // ----------------------------------------------------------------
  // write queue between bus and memory ports
  // ----------------------------------------------------------------
  word_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_in_valid(push),
    .o_in_ready(fifo_in_ready),
    .i_in_data({tgt_q, addr_q, lanes_q, i_dma_bus_write_data}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_out),
    .o_level(fifo_level)
  );

  // ----------------------------------------------------------------
  // bus slave data phase
  // ----------------------------------------------------------------
  // address and control captured at the end of the address phase
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      tgt_q <= dma_tcm_pkg::PORT_INSTR;
      addr_q <= '0;
      lanes_q <= '0;
    end else if (ce && accept && (ph_q == dma_tcm_pkg::PH_IDLE || rdy_q)) begin
      tgt_q <= dma_tcm_pkg::target_port(i_dma_bus_address);
      addr_q <= i_dma_bus_address[MEM_AW+1:2];
      lanes_q <= dma_tcm_pkg::lane_mask(i_dma_bus_size, i_dma_bus_address[1:0],
                                        i_big_endian_select);
    end
  end

  // phase sequencing, ready and response; only two response codes exist
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ph_q <= dma_tcm_pkg::PH_IDLE;
      rdy_q <= 1'b1;
      resp_q <= dma_tcm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ph_q == dma_tcm_pkg::PH_IDLE || rdy_q) begin
        resp_q <= dma_tcm_pkg::RESP_OKAY;
        if (accept && i_dma_bus_write) begin
          ph_q <= dma_tcm_pkg::PH_WRITE;
          rdy_q <= space_ok && !any_wait;
        end else if (accept) begin
          ph_q <= dma_tcm_pkg::PH_RD_ISSUE;
          rdy_q <= 1'b0;
        end else begin
          ph_q <= dma_tcm_pkg::PH_IDLE;
          rdy_q <= 1'b1;
        end
      end else begin
        case (ph_q)
          dma_tcm_pkg::PH_WRITE: begin
            rdy_q <= fifo_in_ready && !any_wait;
          end
          dma_tcm_pkg::PH_RD_ISSUE: begin
            if (quiescent) begin
              ph_q <= dma_tcm_pkg::PH_RD_MEM;
            end
          end
          dma_tcm_pkg::PH_RD_MEM: begin
            if (!wait_v[tgt_q]) begin
              ph_q <= dma_tcm_pkg::PH_RD_RET;
            end
          end
          dma_tcm_pkg::PH_RD_RET: begin
            if (err_v[tgt_q]) begin
              ph_q <= dma_tcm_pkg::PH_ERR;
              resp_q <= dma_tcm_pkg::RESP_ERROR;
            end else begin
              ph_q <= dma_tcm_pkg::PH_RD_DONE;
              rdy_q <= 1'b1;
            end
          end
          dma_tcm_pkg::PH_ERR: begin
            rdy_q <= 1'b1; // second cycle of the error response
          end
          default: begin
            ph_q <= dma_tcm_pkg::PH_IDLE;
            rdy_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // read data is a whole word captured only in the return cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else if (ce && ph_q == dma_tcm_pkg::PH_RD_RET) begin
      rdata_q <= rdata_v[tgt_q];
    end
  end

  // ----------------------------------------------------------------
  // memory ports: 0 instruction, 1 even bank, 2 odd bank
  // ----------------------------------------------------------------
  // each port holds its request while its wait is high; queued writes leave in order,
  // each once its own port is free, so alternating words overlap across banks
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_q <= '0;
      wr_q <= '0;
      maddr_q <= '0;
      mwe_q <= '0;
      mwd_q <= '0;
    end else if (ce) begin
      for (int p = 0; p < 3; p++) begin
        if (pop && head_tgt == 2'(p)) begin
          cs_q[p] <= 1'b1;
          wr_q[p] <= 1'b1;
          maddr_q[p] <= fifo_out[36 +: MEM_AW];
          mwe_q[p] <= fifo_out[35:32];
          mwd_q[p] <= fifo_out[31:0];
        end else if (issue_rd && tgt_q == 2'(p)) begin
          cs_q[p] <= 1'b1;
          wr_q[p] <= 1'b0;
          maddr_q[p] <= addr_q;
          mwe_q[p] <= 4'h0;
        end else if (free_v[p]) begin
          cs_q[p] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // low power sequencing
  // ----------------------------------------------------------------
  assign wake = i_irq || i_fiq || i_external_halt_request;

  // sleep waits for an empty queue and idle ports; wake drops standby at once
  // and lets the core run again one cycle later
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      slp_q <= dma_tcm_pkg::SLP_RUN;
      core_run_q <= 1'b1;
      standby_q <= 1'b0;
    end else begin
      case (slp_q)
        dma_tcm_pkg::SLP_RUN: begin
          if (i_wfi_request) begin
            slp_q <= dma_tcm_pkg::SLP_DRAIN;
          end
        end
        dma_tcm_pkg::SLP_DRAIN: begin
          if (wake) begin
            slp_q <= dma_tcm_pkg::SLP_RUN;
          end else if (quiescent) begin
            slp_q <= dma_tcm_pkg::SLP_SLEEP;
            core_run_q <= 1'b0;
            standby_q <= 1'b1;
          end
        end
        dma_tcm_pkg::SLP_SLEEP: begin
          if (wake) begin
            slp_q <= dma_tcm_pkg::SLP_WAKE;
            standby_q <= 1'b0;
          end
        end
        default: begin
          slp_q <= dma_tcm_pkg::SLP_RUN;
          core_run_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_dma_bus_read_data = rdata_q;
  assign o_dma_bus_response = resp_q;
  assign o_dma_bus_ready_out = rdy_q;
  assign o_instr_mem_cs = cs_q[0];
  assign o_instr_mem_write = wr_q[0];
  assign o_instr_mem_addr = maddr_q[0];
  assign o_instr_mem_byte_we = mwe_q[0];
  assign o_instr_mem_wdata = mwd_q[0];
  assign o_data_mem_cs = cs_q[2:1];
  assign o_data_mem_write = wr_q[2:1];
  assign o_data_mem_addr = {maddr_q[2], maddr_q[1]};
  assign o_data_mem_byte_we = {mwe_q[2], mwe_q[1]};
  assign o_data_mem_wdata = {mwd_q[2], mwd_q[1]};
  assign o_core_clock_run = core_run_q;
  assign o_sleep_standby_flag = standby_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_hold_without_ce: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !ce |=> $stable(rdy_q) && $stable(resp_q) && $stable(cs_q)) else $error("bus state moved without enable");
  a_err_two_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ce && ph_q == dma_tcm_pkg::PH_RD_RET && err_v[tgt_q] |=> resp_q && !rdy_q
    ##1 (!$past(ce) || (resp_q && rdy_q)))
    else $error("error response not two cycles");
  a_err_only_reads: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    resp_q |-> ph_q == dma_tcm_pkg::PH_ERR) else $error("error response outside a read");
  a_idle_ready: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ph_q == dma_tcm_pkg::PH_IDLE |-> rdy_q && !resp_q) else $error("idle port not ready");
  a_read_latency: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ce && accept && !i_dma_bus_write && rdy_q |=> !rdy_q [*2]) else $error("read completed too early");
  a_write_wait: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ce && ph_q == dma_tcm_pkg::PH_WRITE && !rdy_q && any_wait |=> !rdy_q) else $error("write ended during bank wait");
  a_read_wait: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    ce && ph_q == dma_tcm_pkg::PH_RD_MEM && wait_v[tgt_q] |=> !rdy_q && ph_q == dma_tcm_pkg::PH_RD_MEM)
    else $error("read left memory wait");
  a_bank_parity: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (cs_q[1] |-> !maddr_q[1][0]) and (cs_q[2] |-> maddr_q[2][0])) else $error("word sent to wrong bank");
  a_standby_drop: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    standby_q && wake |=> !standby_q && !core_run_q ##1 core_run_q) else $error("wake sequence wrong");
  a_sleep_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(standby_q) |-> $past(quiescent) && !core_run_q) else $error("sleep entered while busy");
endmodule // dma_tcm_port
`default_nettype wire

// File: tb/tcm_mem_model.sv
// memory model standing behind the instruction port and the two data banks
// assumes the port holds each request steady while the matching wait is high
`timescale 1ns/1ns
`default_nettype none
module tcm_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wait_en,
  input wire logic i_err_en,
  input wire logic i_instr_cs,
  input wire logic i_instr_write,
  input wire logic [21:0] i_instr_addr,
  input wire logic [3:0] i_instr_we,
  input wire logic [31:0] i_instr_wdata,
  output logic [31:0] o_instr_rdata,
  output logic o_instr_wait,
  output logic o_instr_error,
  input wire logic [1:0] i_data_cs,
  input wire logic [1:0] i_data_write,
  input wire logic [1:0][21:0] i_data_addr,
  input wire logic [1:0][3:0] i_data_we,
  input wire logic [1:0][31:0] i_data_wdata,
  output logic [1:0][31:0] o_data_rdata,
  output logic o_even_wait,
  output logic o_odd_wait,
  output logic [1:0] o_data_error,
  output logic [2:0][7:0] o_wr_cnt
);
  logic [2:0] cs, wr, ret_q, wt_q;
  logic [2:0][21:0] ad;
  logic [2:0][3:0] we;
  logic [2:0][31:0] wd, rd_q;
  logic [31:0] mem [logic [23:0]];
  logic [31:0] tmp;
  // port 0 instruction, 1 even bank, 2 odd bank
  assign cs = {i_data_cs, i_instr_cs};
  assign wr = {i_data_write, i_instr_write};
  assign ad = {i_data_addr, i_instr_addr};
  assign we = {i_data_we, i_instr_we};
  assign wd = {i_data_wdata, i_instr_wdata};
  // accept on enabled edges, answer a read in the next cycle
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ret_q <= 3'h0;
      wt_q <= 3'h0;
      o_wr_cnt <= '0;
    end else if (i_ce) begin
      for (int p = 0; p < 3; p++) begin
        wt_q[p] <= i_wait_en & 1'($urandom);
        ret_q[p] <= cs[p] & ~wr[p] & ~wt_q[p];
        tmp = mem.exists({p[1:0], ad[p]}) ? mem[{p[1:0], ad[p]}] : 32'h0;
        if (cs[p] && !wt_q[p] && wr[p]) begin
          for (int b = 0; b < 4; b++) if (we[p][b]) tmp[8*b+:8] = wd[p][8*b+:8];
          mem[{p[1:0], ad[p]}] = tmp;
          o_wr_cnt[p] <= o_wr_cnt[p] + 8'h1;
        end else if (cs[p] && !wt_q[p]) rd_q[p] <= tmp;
      end
    end
  end
  // outside a return cycle the read lines show the inverse of the last word
  assign o_instr_rdata = ret_q[0] ? rd_q[0] : ~rd_q[0];
  assign o_data_rdata[0] = ret_q[1] ? rd_q[1] : ~rd_q[1];
  assign o_data_rdata[1] = ret_q[2] ? rd_q[2] : ~rd_q[2];
  assign o_instr_wait = wt_q[0];
  assign o_even_wait = wt_q[1];
  assign o_odd_wait = wt_q[2];
  // errors flagged on read returns and, to be ignored, on writes
  assign o_instr_error = i_err_en & (ret_q[0] | (cs[0] & wr[0]));
  assign o_data_error = {2{i_err_en}} & (ret_q[2:1] | (cs[2:1] & wr[2:1]));
endmodule // tcm_mem_model
`default_nettype wire

// File: tb/tb_dma_tcm_port.sv
// self-checking bench for the dma memory port with a memory model behind it
// assumes a single slave, so the segment ready is the port's own ready
`timescale 1ns/1ns
`default_nettype none
module tb_dma_tcm_port;
  logic clk_sys = 0, nrst = 0, ce = 1, ce_rand = 0, big = 0, sel = 0, wr = 0, wfi = 0, wait_en = 0, err_en = 0;
  logic [2:0] wake = 3'h0;
  logic [31:0] addr = 0, wdata = 0;
  logic [1:0] trans = 0;
  logic [2:0] size = 0;
  logic [3:0] prot = 0;
  logic [31:0] rdata, im_wd, im_rd, rd, base, d;
  logic resp, ready, im_cs, im_wr, im_er, im_wt, ev_wt, od_wt, run, standby, rs, le;
  logic [21:0] im_ad;
  logic [3:0] im_we;
  logic [1:0] dm_cs, dm_wr, dm_er;
  logic [1:0][21:0] dm_ad;
  logic [1:0][3:0] dm_we;
  logic [1:0][31:0] dm_wd, dm_rd;
  logic [2:0][7:0] cnt, cnt0;
  int error_cnt = 0, comparisons = 0;
  always #4 clk_sys = ~clk_sys;
  // random bus tick ratio while enabled
  always @(posedge clk_sys) ce <= #1 (ce_rand ? 1'($urandom) : 1'b1);
  dma_tcm_port dut_u (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_dma_clock_enable(ce), .i_big_endian_select(big),
    .i_dma_bus_select(sel), .i_dma_bus_address(addr), .i_dma_bus_transfer_type(trans), .i_dma_bus_size(size),
    .i_dma_bus_write(wr), .i_dma_bus_protection(prot), .i_dma_bus_write_data(wdata), .i_dma_bus_ready_in(ready),
    .o_dma_bus_read_data(rdata), .o_dma_bus_response(resp), .o_dma_bus_ready_out(ready), .o_instr_mem_cs(im_cs),
    .o_instr_mem_write(im_wr), .o_instr_mem_addr(im_ad), .o_instr_mem_byte_we(im_we), .o_instr_mem_wdata(im_wd),
    .i_instr_mem_rdata(im_rd), .i_instr_mem_wait(im_wt), .i_instr_mem_error(im_er), .o_data_mem_cs(dm_cs),
    .o_data_mem_write(dm_wr), .o_data_mem_addr(dm_ad), .o_data_mem_byte_we(dm_we), .o_data_mem_wdata(dm_wd),
    .i_data_mem_rdata(dm_rd), .i_even_bank_wait(ev_wt), .i_odd_bank_wait(od_wt), .i_data_mem_error(dm_er),
    .i_wfi_request(wfi), .i_irq(wake[0]), .i_fiq(wake[1]), .i_external_halt_request(wake[2]),
    .o_core_clock_run(run), .o_sleep_standby_flag(standby));
  tcm_mem_model mem_u (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(ce), .i_wait_en(wait_en), .i_err_en(err_en),
    .i_instr_cs(im_cs), .i_instr_write(im_wr), .i_instr_addr(im_ad), .i_instr_we(im_we), .i_instr_wdata(im_wd),
    .o_instr_rdata(im_rd), .o_instr_wait(im_wt), .o_instr_error(im_er), .i_data_cs(dm_cs), .i_data_write(dm_wr),
    .i_data_addr(dm_ad), .i_data_we(dm_we), .i_data_wdata(dm_wd), .o_data_rdata(dm_rd), .o_even_wait(ev_wt),
    .o_odd_wait(od_wt), .o_data_error(dm_er), .o_wr_cnt(cnt));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one transfer: address phase, then data phase until ready on an enabled edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] dw);
    int n;
    n = 0;
    le = 0;
    #1 sel = 1;
    trans = 2'h2;
    addr = a;
    size = s;
    wr = w;
    prot = 4'($urandom);
    do begin @(posedge clk_sys); n++; end while (!(ce && ready) && n < 3000);
    #1 sel = 0;
    trans = 2'h0;
    wdata = dw;
    do begin @(posedge clk_sys); n++; if (ce && !ready && resp) le = 1; end while (!(ce && ready) && n < 3000);
    rd = rdata;
    rs = resp;
    if (n >= 3000) begin error_cnt++; report_and_stop(); end
  endtask
  // byte lanes expected for size, offset and endian
  function automatic logic [3:0] lanes(input logic b, input logic [2:0] s, input logic [1:0] o);
    logic [3:0] m;
    m = (s == 3'h0) ? (4'h1 << o) : (s == 3'h1) ? (o[1] ? 4'hc : 4'h3) : 4'hf;
    if (b && s == 3'h0) m = 4'h8 >> o;
    else if (b && s == 3'h1) m = ~m;
    return m;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] b0, input logic [31:0] dn, input logic [3:0] m);
    for (int i = 0; i < 4; i++) if (m[i]) b0[8*i+:8] = dn[8*i+:8];
    return b0;
  endfunction
  // sleep entry and wake by one source
  task automatic sleep_wake(input int j);
    @(posedge clk_sys);
    #1 wfi = 1;
    @(posedge clk_sys);
    #1 wfi = 0;
    for (int n = 0; n < 100 && standby !== 1'b1; n++) @(posedge clk_sys);
    #1 chk(standby, 1);
    chk(run, 0);
    xfer(1, 32'h00800040 + 4 * j, 3'h2, 32'h5a00_0000 + j);
    xfer(0, 32'h00800040 + 4 * j, 3'h2, 0);
    chk(rd, 32'h5a00_0000 + j);
    #1 wake[j] = 1;
    @(posedge clk_sys);
    #1 chk(standby, 0);
    chk(run, 0);
    @(posedge clk_sys);
    #1 chk(run, 1);
    wake[j] = 0;
  endtask
  initial begin
    logic [31:0] a;
    logic [2:0] s;
    logic [1:0] o;
    void'($urandom(9213));
    repeat (20) @(posedge clk_sys);
    #1 nrst = 1;
    chk(ready, 1);
    chk(resp, 0);
    // lane table in both endian modes, instruction and data regions
    for (int e = 0; e < 2; e++) for (int k = 0; k < 7; k++) begin
      big = e[0];
      s = (k < 4) ? 3'h0 : (k < 6) ? 3'h1 : 3'h2;
      o = (k < 4) ? 2'(k) : (k == 5) ? 2'h2 : 2'h0;
      a = ($urandom & 32'h00fffffc) | o;
      base = $urandom;
      d = $urandom;
      xfer(1, a & ~32'h3, 3'h2, base);
      xfer(1, a, s, d);
      xfer(0, a, s, 0);
      chk(rd, merge(base, d, lanes(e[0], s, o)));
      chk(rs, 0);
    end
    // random traffic with stretched bus ticks and memory waits
    big = 0;
    ce_rand = 1;
    wait_en = 1;
    for (int i = 0; i < 30; i++) begin
      a = $urandom & 32'h00fffffc;
      d = $urandom;
      xfer(1, a, 3'h2, d);
      xfer(0, a, 3'h2, 0);
      chk(rd, d);
    end
    // pipelined sequential block write of eight words: next address rides in each data phase
    cnt0 = cnt;
    for (int i = 0; i <= 8; i++) begin
      #1 sel = (i < 8);
      trans = (i == 0) ? 2'h2 : (i < 8) ? 2'h3 : 2'h0;
      addr = 32'h00800100 + 4 * i;
      size = 3'h2;
      wr = 1;
      if (i > 0) wdata = 32'h0b10_c000 + i - 1;
      do begin @(posedge clk_sys); end while (!(ce && ready));
    end
    // a read waits for the queue to drain, so the counts below are final
    xfer(0, 32'h0080011c, 3'h2, 0);
    chk(rd, 32'h0b10_c007);
    chk(cnt[1] - cnt0[1], 4);
    chk(cnt[2] - cnt0[2], 4);
    chk(cnt[0] - cnt0[0], 0);
    // memory error: ignored on writes, two-cycle error on reads
    err_en = 1;
    xfer(1, 32'h00000200, 3'h2, 32'h1234_5678);
    chk(rs, 0);
    xfer(0, 32'h00000200, 3'h2, 0);
    chk(rs, 1);
    chk(le, 1);
    err_en = 0;
    xfer(0, 32'h00000200, 3'h2, 0);
    chk(rs, 0);
    chk(rd, 32'h1234_5678);
    ce_rand = 0;
    wait_en = 0;
    for (int j = 0; j < 3; j++) sleep_wake(j);
    report_and_stop();
  end
  // hang guard
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_dma_tcm_port
`default_nettype wire
